// File: core/can_lec_pkg.sv
// Constants, codes and carriers for the last-error status logic.
// Assumes the protocol engine and the status logic share one clock.
package can_last_error_pkg;

  // ==========================================================
  // Status register layout
  localparam int STATUS_WIDTH = 32;
  localparam int FIELD_LSB = 0;
  localparam int FIELD_MSB = 2;
  localparam int FIELD_WIDTH = FIELD_MSB - FIELD_LSB + 1;
  localparam int ACT_LSB = 3;
  localparam int ACT_MSB = 4;
  localparam int ERR_PASSIVE_BIT = 5;
  localparam int WARNING_BIT = 6;
  localparam int BUS_OFF_BIT = 7;
  localparam int RESERVED_LSB = 8;

  // ==========================================================
  // Bus-off recovery
  localparam int RECOVERY_RUN_BITS = 11;

  // ==========================================================
  // Last-error codes
  typedef enum logic [2:0] {
    NO_ERROR_CODE = 3'h0,
    STUFF_ERROR_CODE = 3'h1,
    FORM_ERROR_CODE = 3'h2,
    NO_ACKNOWLEDGE_CODE = 3'h3,
    RECESSIVE_MISMATCH_CODE = 3'h4,
    DOMINANT_MISMATCH_CODE = 3'h5,
    CHECKSUM_MISMATCH_CODE = 3'h6,
    NO_EVENT_CODE = 3'h7
  } last_error_code_type;

  localparam last_error_code_type FIELD_RESET = NO_EVENT_CODE;

  // ==========================================================
  // Activity field
  typedef enum logic [1:0] {
    ACT_SYNC = 2'h0,
    ACT_IDLE = 2'h1,
    ACT_RECEIVER = 2'h2,
    ACT_TRANSMITTER = 2'h3
  } activity_type;

  // ==========================================================
  // Carriers
  // One-cycle pulses from the protocol engine
  typedef struct packed {
    logic stuffError;
    logic formError;
    logic noAcknowledge;
    logic recessiveMismatch;
    logic dominantMismatch;
    logic checksumError;
    logic transferOk;
  } error_events_type;

  // Levels from the fault confinement and bit stream logic
  typedef struct packed {
    activity_type activity;
    logic errPassive;
    logic warning;
    logic busOff;
  } node_state_type;

endpackage : can_last_error_pkg

// File: core/recessive_run_counter.sv
// Counts consecutive recessive bits while bus-off recovery runs.
// Assumes bitTick is a one-cycle pulse at each bit's sample point and
// busLevel is the sampled bus level on the same clock (1 = recessive).
`timescale 1ns/100ps
`default_nettype none

module recessive_run_counter
  import can_last_error_pkg::*;
#(
  parameter int RUN_LEN = RECOVERY_RUN_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bit stream
  input wire logic enable,
  input wire logic bitTick,
  input wire logic busLevel,
  // Result
  output logic runDone
);

  localparam int CW = $clog2(RUN_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(RUN_LEN - 1);
  localparam logic [CW-1:0] ZERO = '0;
  localparam logic [CW-1:0] ONE = CW'(1);

  // A run shorter than two cannot be told apart from a single bit
  if (RUN_LEN < 2) begin : gBadLen
    $error("RUN_LEN must be at least 2");
  end

  logic [CW-1:0] count_reg, count_next;
  logic runDone_reg, runDone_next;

  // ==========================================================
  // Run counting
  always_comb begin
    count_next = count_reg;
    runDone_next = 1'b0;
    if (!enable) begin
      count_next = ZERO;
    end else if (bitTick) begin
      if (!busLevel) begin
        // A dominant bit breaks the run
        count_next = ZERO;
      end else if (count_reg == LAST) begin
        // Restart so every further run of eleven is reported
        count_next = ZERO;
        runDone_next = 1'b1;
      end else begin
        count_next = count_reg + ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= ZERO;
      runDone_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      runDone_reg <= runDone_next;
    end
  end

  assign runDone = runDone_reg;

endmodule : recessive_run_counter

`default_nettype wire

// File: core/can_last_error_status.sv
// Status register of a CAN node holding the last-error field.
// Assumes the protocol engine delivers qualified one-cycle error pulses
// and the bit stream, all on clk; software reads through readStrobe.
`timescale 1ns/100ps
`default_nettype none

module can_last_error_status
  import can_last_error_pkg::*;
#(
  parameter int RECOVERY_RUN = RECOVERY_RUN_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Protocol engine events and node state
  input wire error_events_type events,
  input wire logic inArbitration,
  input wire node_state_type nodeState,
  // Bit stream for bus-off recovery tracking
  input wire logic bitTick,
  input wire logic busLevel,
  // Register read port
  input wire logic readStrobe,
  output logic [STATUS_WIDTH-1:0] readData,
  output logic readValid,
  // Live view of the field
  output last_error_code_type lastErrorField
);

  if (RECOVERY_RUN < 2) begin : gBadRun
    $error("RECOVERY_RUN must be at least 2");
  end

  // ==========================================================
  // Recovery run detection
  logic recoveryRun;

  recessive_run_counter #(
    .RUN_LEN(RECOVERY_RUN)
  ) runCounter (
    .clk(clk),
    .rst_n(rst_n),
    .enable(nodeState.busOff),
    .bitTick(bitTick),
    .busLevel(busLevel),
    .runDone(recoveryRun)
  );

  // ==========================================================
  // Error classification
  // Several reports in one cycle are rare; the bit-level mismatches
  // win because they are what the node itself caused.
  function automatic logic pick_error(
    input error_events_type ev,
    input logic arb,
    input logic recov,
    output last_error_code_type code
  );
    logic hit;
    hit = 1'b1;
    code = NO_EVENT_CODE;
    if (ev.dominantMismatch || recov) begin
      code = DOMINANT_MISMATCH_CODE;
    end else if (ev.recessiveMismatch && !arb) begin
      // Losing arbitration is not an error
      code = RECESSIVE_MISMATCH_CODE;
    end else if (ev.stuffError) begin
      code = STUFF_ERROR_CODE;
    end else if (ev.formError) begin
      code = FORM_ERROR_CODE;
    end else if (ev.checksumError) begin
      code = CHECKSUM_MISMATCH_CODE;
    end else if (ev.noAcknowledge) begin
      code = NO_ACKNOWLEDGE_CODE;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction : pick_error

  function automatic logic [STATUS_WIDTH-1:0] pack_status(
    input last_error_code_type code,
    input node_state_type st
  );
    logic [STATUS_WIDTH-1:0] word;
    word = '0;
    word[FIELD_MSB:FIELD_LSB] = code;
    word[ACT_MSB:ACT_LSB] = st.activity;
    word[ERR_PASSIVE_BIT] = st.errPassive;
    word[WARNING_BIT] = st.warning;
    word[BUS_OFF_BIT] = st.busOff;
    return word;
  endfunction : pack_status

  // ==========================================================
  // Last-error field
  last_error_code_type field_reg, field_next;
  last_error_code_type errCode;
  logic errHit;

  always_comb begin
    errCode = NO_EVENT_CODE;
    errHit = pick_error(events, inArbitration, recoveryRun, errCode);
    field_next = field_reg;
    // A fresh event beats the read side effect in the same cycle
    if (errHit) begin
      field_next = errCode;
    end else if (events.transferOk) begin
      field_next = NO_ERROR_CODE;
    end else if (readStrobe) begin
      field_next = NO_EVENT_CODE;
    end
  end

  // ==========================================================
  // Read port
  logic [STATUS_WIDTH-1:0] readData_reg, readData_next;
  logic readValid_reg, readValid_next;

  always_comb begin
    readValid_next = readStrobe;
    readData_next = readData_reg;
    if (readStrobe) begin
      // Value before the read side effect is returned
      readData_next = pack_status(field_reg, nodeState);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      field_reg <= FIELD_RESET;
      readData_reg <= '0;
      readValid_reg <= 1'b0;
    end else begin
      field_reg <= field_next;
      readData_reg <= readData_next;
      readValid_reg <= readValid_next;
    end
  end

  assign readData = readData_reg;
  assign readValid = readValid_reg;
  assign lastErrorField = field_reg;

endmodule : can_last_error_status

`default_nettype wire

// File: tb/can_bus_model.sv
// Bus seen through the node's bit sampler.
// Assumes one bit every four clocks.
`timescale 1ns/100ps
`default_nettype none
module can_bus_model (
  // Clock
  input wire logic clk,
  // Bench control
  input wire logic en,
  input wire logic dominant,
  // Sampled bus
  output logic bitTick = 1'b0,
  output logic busLevel = 1'b1
);
  logic [1:0] phase_reg = 2'h0;
  // ==========
  // Bit timing
  always_ff @(posedge clk) begin
    phase_reg <= phase_reg + 2'h1;
    bitTick <= en && (phase_reg == 2'h3);
    // Idle bus returns to recessive
    busLevel <= !(en && dominant);
  end
endmodule : can_bus_model
`default_nettype wire

// File: tb/can_last_error_status_sva.sv
// Assertions on the last-error status ports.
// Assumes binding to can_last_error_status.
`timescale 1ns/100ps
`default_nettype none
module can_last_error_status_sva
  import can_last_error_pkg::*;
#(
  parameter int RECOVERY_RUN = RECOVERY_RUN_BITS
) (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire error_events_type events,
  input wire logic inArbitration,
  input wire node_state_type nodeState,
  input wire logic bitTick,
  input wire logic busLevel,
  input wire logic readStrobe,
  input wire logic [STATUS_WIDTH-1:0] readData,
  input wire logic readValid,
  input wire last_error_code_type lastErrorField
);
  int run_reg;
  int run_next;
  logic runHit;
  // ==========
  // Recessive run tracker
  always_comb begin
    run_next = run_reg;
    runHit = 1'b0;
    if (!nodeState.busOff || (bitTick && !busLevel)) begin
      run_next = 0;
    end else if (bitTick) begin
      runHit = (run_reg == RECOVERY_RUN - 1);
      run_next = runHit ? 0 : run_reg + 1;
    end
  end
  always_ff @(posedge clk) begin
    run_reg <= rst_n ? run_next : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_answer;
    readValid && readData[FIELD_MSB:FIELD_LSB] == $past(lastErrorField)
      && readData[STATUS_WIDTH-1:RESERVED_LSB] == '0;
  endsequence
  property p_load(logic ev, last_error_code_type c);
    ev && $onehot(events) && !nodeState.busOff |=> lastErrorField == c;
  endproperty
  a_stuff_load: assert property (
    p_load(events.stuffError, STUFF_ERROR_CODE))
    else $error("stuff code");
  a_form_load: assert property (
    p_load(events.formError, FORM_ERROR_CODE))
    else $error("form code");
  a_ack_load: assert property (
    p_load(events.noAcknowledge, NO_ACKNOWLEDGE_CODE))
    else $error("acknowledge code");
  a_rec_load: assert property (
    p_load(events.recessiveMismatch && !inArbitration,
      RECESSIVE_MISMATCH_CODE))
    else $error("recessive code");
  a_dom_load: assert property (
    p_load(events.dominantMismatch, DOMINANT_MISMATCH_CODE))
    else $error("dominant code");
  a_sum_load: assert property (
    p_load(events.checksumError, CHECKSUM_MISMATCH_CODE))
    else $error("checksum code");
  a_clean_clear: assert property (
    p_load(events.transferOk, NO_ERROR_CODE))
    else $error("clear code");
  a_error_code: assert property (
    events.stuffError || events.formError || events.noAcknowledge
    || events.dominantMismatch || events.checksumError
    |=> lastErrorField != NO_EVENT_CODE)
    else $error("error shown as no event");
  a_arb_ignore: assert property (events == 7'h08 && inArbitration
    && !readStrobe && !nodeState.busOff |=> $stable(lastErrorField))
    else $error("arbitration");
  a_read_sets: assert property (readStrobe && events == '0
    && !nodeState.busOff |=> lastErrorField == NO_EVENT_CODE)
    else $error("read side effect");
  a_read_word: assert property (readStrobe |=> s_answer)
    else $error("read word");
  a_run_load: assert property (runHit |-> ##[1:3] lastErrorField == 3'h5)
    else $error("recovery run");
endmodule : can_last_error_status_sva
bind can_last_error_status can_last_error_status_sva #(
  .RECOVERY_RUN(RECOVERY_RUN)) u_sva (.clk(clk), .rst_n(rst_n),
  .events(events), .inArbitration(inArbitration), .nodeState(nodeState),
  .bitTick(bitTick), .busLevel(busLevel), .readStrobe(readStrobe),
  .readData(readData), .readValid(readValid),
  .lastErrorField(lastErrorField));
`default_nettype wire

// File: tb/can_last_error_status_tb.sv
// Self-checking bench for the last-error status logic.
// Assumes a 25 MHz clock and can_bus_model as the bus.
`timescale 1ns/100ps
`default_nettype none
module can_last_error_status_tb
  import can_last_error_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, inArb = 1'b0, rdStb = 1'b0;
  logic busEn = 1'b0, busDom = 1'b0, bitTick, busLevel, readValid;
  error_events_type events = '0;
  node_state_type nodeState = '0;
  logic [31:0] readData;
  last_error_code_type lastErrorField;
  int n_fail = 0, cmp_count = 0;
  can_last_error_status u_dut (.clk(clk), .rst_n(rst_n), .events(events),
    .inArbitration(inArb), .nodeState(nodeState), .bitTick(bitTick),
    .busLevel(busLevel), .readStrobe(rdStb), .readData(readData),
    .readValid(readValid), .lastErrorField(lastErrorField));
  can_bus_model u_bus (.clk(clk), .en(busEn), .dominant(busDom),
    .bitTick(bitTick), .busLevel(busLevel));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(logic [6:0] ev);
    events = ev;
    step();
    events = '0;
  endtask : pulse
  task automatic test_codes;
    logic [2:0] exp [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
    for (int i = 0; i < 7; i++) begin
      pulse(7'h40 >> i);
      chk("code", exp[i], lastErrorField);
    end
    $display("test_codes done");
  endtask : test_codes
  task automatic test_arb;
    pulse(7'h20);
    inArb = 1'b1;
    pulse(7'h08);
    chk("arb", 32'h2, lastErrorField);
    // A lost-arbitration mismatch must not hide a stuff error beside it
    pulse(7'h48);
    inArb = 1'b0;
    chk("arb stuff", 32'h1, lastErrorField);
    $display("test_arb done");
  endtask : test_arb
  task automatic test_read;
    nodeState = '{ACT_TRANSMITTER, 1'b1, 1'b1, 1'b0};
    rdStb = 1'b1;
    step();
    chk("valid", 32'h1, readValid);
    chk("word", 32'h79, readData);
    step();
    rdStb = 1'b0;
    chk("word2", 32'h7f, readData);
    $display("test_read done");
  endtask : test_read
  task automatic test_run;
    nodeState.busOff = 1'b1;
    busEn = 1'b1;
    // The model ticks every fourth edge from its free-running phase:
    // the eleventh recessive tick is taken 43 edges in, the code one later
    step(43);
    chk("early", NO_EVENT_CODE, lastErrorField);
    step();
    chk("run", DOMINANT_MISMATCH_CODE, lastErrorField);
    rdStb = 1'b1;
    step();
    rdStb = 1'b0;
    chk("reread", NO_EVENT_CODE, lastErrorField);
    // One dominant tick restarts the count; without it the code
    // would come back four edges earlier
    busDom = 1'b1;
    step();
    busDom = 1'b0;
    step(45);
    chk("broken", NO_EVENT_CODE, lastErrorField);
    step();
    chk("rerun", DOMINANT_MISMATCH_CODE, lastErrorField);
    busEn = 1'b0;
    nodeState.busOff = 1'b0;
    $display("test_run done");
  endtask : test_run
  task automatic results;
    $display("Compared %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    step(6);
    rst_n = 1'b1;
    chk("reset", NO_EVENT_CODE, lastErrorField);
    test_codes();
    test_arb();
    test_read();
    test_run();
    results();
  end
  initial begin
    step(2000);
    n_fail++;
    results();
  end
endmodule : can_last_error_status_tb
`default_nettype wire
